// File: src/btc_exec.sv
// Executing core for bit force, bit-test skips and subroutine call
`timescale 1ns/1ps
module btc_exec
  import btc_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Program memory
  output logic [BTC_PC_W-1:0] fetch_addr,
  input wire logic [BTC_WORD_W-1:0] instr_word,
  input wire logic instr_valid,
  // Core status byte
  input wire logic [BTC_DATA_W-1:0] status_in,
  // File register read
  output logic [BTC_FADDR_W-1:0] file_rd_addr,
  input wire logic [BTC_DATA_W-1:0] file_rd_data,
  // File register write
  output logic file_wr_en,
  output logic [BTC_FADDR_W-1:0] file_wr_addr,
  output logic [BTC_DATA_W-1:0] file_wr_data,
  // Return stack
  output logic stack_push,
  output logic [BTC_PC_W-1:0] stack_push_data,
  // Instructions this block does not execute
  output logic other_valid,
  output logic [BTC_WORD_W-1:0] other_word,
  // Cycle markers
  output logic instr_done,
  output logic nop_slot
);

  typedef struct packed {
    btc_state_e state;
    logic [BTC_PC_W-1:0] pc;
    logic wr_en;
    logic [BTC_FADDR_W-1:0] wr_addr;
    logic [BTC_DATA_W-1:0] wr_data;
    logic push;
    logic [BTC_PC_W-1:0] push_data;
    logic other;
    logic [BTC_WORD_W-1:0] other_word;
    logic done;
    logic nop;
  } btc_core_s;

  btc_core_s s_q;
  btc_core_s s_d;
  logic tested_bit;
  logic [BTC_PC_W-1:0] pc_next;
  logic exec_now;

  btc_dec_if d ();

  btc_decode u_decode (
    .d(d)
  );

  assign d.word = instr_word;
  assign exec_now = (s_q.state == BTC_EXEC) && instr_valid;
  assign pc_next = s_q.pc + BTC_PC_W'(1);
  assign tested_bit = |(file_rd_data & d.mask);

  always_comb begin
    s_d = s_q;
    // Strobes last one instruction cycle
    s_d.wr_en = 1'b0;
    s_d.push = 1'b0;
    s_d.other = 1'b0;
    s_d.done = 1'b0;
    s_d.nop = 1'b0;
    case (s_q.state)
      BTC_EXEC: begin
        if (instr_valid) begin
          s_d.pc = pc_next;
          s_d.done = 1'b1;
          if (d.is_force) begin
            // Read-modify-write of file f only; status is never written
            s_d.wr_en = 1'b1;
            s_d.wr_addr = d.faddr;
            s_d.wr_data = file_rd_data | d.mask;
          end else if (d.is_skip_low) begin
            if (!tested_bit) begin
              s_d.state = BTC_SKIP_NOP;
              s_d.done = 1'b0;
            end
          end else if (d.is_skip_high) begin
            if (tested_bit) begin
              s_d.state = BTC_SKIP_NOP;
              s_d.done = 1'b0;
            end
          end else if (d.is_call) begin
            s_d.push = 1'b1;
            s_d.push_data = pc_next;
            s_d.pc[BTC_DATA_W-1:0] = d.lit;
            s_d.pc[BTC_PC_ZERO_BIT] = 1'b0;
            s_d.pc[BTC_PC_PAGE_LSB +: 2] = status_in[BTC_STATUS_PAGE_LSB +: 2];
            s_d.state = BTC_CALL_NOP;
            s_d.done = 1'b0;
          end else begin
            s_d.other = 1'b1;
            s_d.other_word = instr_word;
          end
        end
      end
      BTC_SKIP_NOP: begin
        // The prefetched word is consumed and dropped in place of a NOP
        if (instr_valid) begin
          s_d.pc = pc_next;
          s_d.nop = 1'b1;
          s_d.done = 1'b1;
          s_d.state = BTC_EXEC;
        end
      end
      BTC_CALL_NOP: begin
        // Second call cycle needs no word; target is fetched during it and executed after it
        s_d.nop = 1'b1;
        s_d.done = 1'b1;
        s_d.state = BTC_EXEC;
      end
      default: begin
        s_d.state = BTC_EXEC;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q.state <= BTC_EXEC;
      s_q.pc <= BTC_PC_RESET;
      s_q.wr_en <= 1'b0;
      s_q.wr_addr <= BTC_FADDR_RESET;
      s_q.wr_data <= BTC_DATA_RESET;
      s_q.push <= 1'b0;
      s_q.push_data <= BTC_PC_RESET;
      s_q.other <= 1'b0;
      s_q.other_word <= BTC_WORD_RESET;
      s_q.done <= 1'b0;
      s_q.nop <= 1'b0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // Read address follows the word on the bus so the test sees f in the same cycle
  assign file_rd_addr = d.faddr;
  assign fetch_addr = s_q.pc;
  assign file_wr_en = s_q.wr_en;
  assign file_wr_addr = s_q.wr_addr;
  assign file_wr_data = s_q.wr_data;
  assign stack_push = s_q.push;
  assign stack_push_data = s_q.push_data;
  assign other_valid = s_q.other;
  assign other_word = s_q.other_word;
  assign instr_done = s_q.done;
  assign nop_slot = s_q.nop;

  a_force_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (clk_en && exec_now && d.is_force) |=>
      (file_wr_en && file_wr_data == ($past(file_rd_data) | $past(d.mask))
       && file_wr_addr == $past(d.faddr)))
    else $error("bit force did not write the set bit");

  a_skip_low: assert property (@(posedge mclk) disable iff (!rst_n)
    (clk_en && exec_now && d.is_skip_low) |=>
      ((s_q.state == BTC_SKIP_NOP) == !$past(tested_bit)))
    else $error("skip on low bit taken wrongly");

  a_skip_high: assert property (@(posedge mclk) disable iff (!rst_n)
    (clk_en && exec_now && d.is_skip_high) |=>
      ((s_q.state == BTC_SKIP_NOP) == $past(tested_bit)))
    else $error("skip on high bit taken wrongly");

  a_skip_discard: assert property (@(posedge mclk) disable iff (!rst_n)
    (clk_en && s_q.state == BTC_SKIP_NOP && instr_valid) |=>
      (nop_slot && !file_wr_en && !stack_push && !other_valid
       && s_q.state == BTC_EXEC && s_q.pc == $past(s_q.pc) + BTC_PC_W'(1)))
    else $error("skipped word was not discarded");

  a_call_push: assert property (@(posedge mclk) disable iff (!rst_n)
    (clk_en && exec_now && d.is_call) |=>
      (stack_push && stack_push_data == $past(s_q.pc) + BTC_PC_W'(1)))
    else $error("call did not push return address");

  a_call_low: assert property (@(posedge mclk) disable iff (!rst_n)
    (clk_en && exec_now && d.is_call) |=> (fetch_addr[7:0] == $past(d.lit)))
    else $error("call literal not in low byte");

  a_call_page: assert property (@(posedge mclk) disable iff (!rst_n)
    (clk_en && exec_now && d.is_call) |=>
      (fetch_addr[10:9] == $past(status_in[6:5]) && !fetch_addr[8]))
    else $error("call page bits wrong");

  a_call_cycles: assert property (@(posedge mclk) disable iff (!rst_n)
    (clk_en && exec_now && d.is_call) ##1 clk_en |=>
      (nop_slot && instr_done && s_q.state == BTC_EXEC && $stable(fetch_addr)))
    else $error("call did not end after two cycles");

  a_push_cause: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(stack_push) || (stack_push && $changed(stack_push_data)) |->
      ($past(clk_en) && $past(exec_now) && $past(d.is_call)))
    else $error("stack push without a call");

  // A stall in the skip slot must not retire the dropped word early
  a_skip_wait: assert property (@(posedge mclk) disable iff (!rst_n)
    (clk_en && s_q.state == BTC_SKIP_NOP && !instr_valid) |=>
      (s_q.state == BTC_SKIP_NOP && !nop_slot && $stable(fetch_addr)))
    else $error("skip slot retired without a word");

  // Only a bit force writes the file; status is never among the targets
  a_no_stray_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (clk_en && !(exec_now && d.is_force)) |=> !file_wr_en)
    else $error("file written by a word that is not a force");

endmodule : btc_exec

// File: src/btc_pkg.sv
// Constants and types shared by the bit-test-and-call decode block
package btc_pkg;

  // Widths of the instruction word, program counter and file register path
  localparam int BTC_WORD_W = 12;
  localparam int BTC_PC_W = 11;
  localparam int BTC_DATA_W = 8;
  localparam int BTC_FADDR_W = 5;
  localparam int BTC_BSEL_W = 3;
  localparam int BTC_OPC_W = 4;

  // Field positions inside the instruction word
  localparam int BTC_OPC_LSB = 8;
  localparam int BTC_BSEL_LSB = 5;
  localparam int BTC_FADDR_LSB = 0;
  localparam int BTC_LIT_LSB = 0;

  // Opcode patterns in the top nibble
  localparam logic [3:0] BTC_OPC_BIT_FORCE = 4'h5;
  localparam logic [3:0] BTC_OPC_SKIP_LOW = 4'h6;
  localparam logic [3:0] BTC_OPC_SKIP_HIGH = 4'h7;
  localparam logic [3:0] BTC_OPC_CALL = 4'h9;

  // Status page bits and their place in the program counter
  localparam int BTC_STATUS_PAGE_LSB = 5;
  localparam int BTC_PC_PAGE_LSB = 9;
  localparam int BTC_PC_ZERO_BIT = 8;

  // Reset values
  localparam logic [10:0] BTC_PC_RESET = 11'h000;
  localparam logic [11:0] BTC_WORD_RESET = 12'h000;
  localparam logic [7:0] BTC_DATA_RESET = 8'h00;
  localparam logic [4:0] BTC_FADDR_RESET = 5'h00;

  // Instruction cycle counts
  localparam int BTC_CYC_SKIP_TAKEN = 2;
  localparam int BTC_CYC_CALL = 2;

  typedef enum logic [1:0] {
    BTC_EXEC,
    BTC_SKIP_NOP,
    BTC_CALL_NOP
  } btc_state_e;

endpackage : btc_pkg

// File: src/btc_dec_if.sv
// Decoded instruction fields passed from the decoder to the executing core
`timescale 1ns/1ps
interface btc_dec_if;
  import btc_pkg::*;
  logic [BTC_WORD_W-1:0] word;
  logic is_force;
  logic is_skip_low;
  logic is_skip_high;
  logic is_call;
  logic [BTC_BSEL_W-1:0] bsel;
  logic [BTC_FADDR_W-1:0] faddr;
  logic [BTC_DATA_W-1:0] lit;
  logic [BTC_DATA_W-1:0] mask;

  modport dec (
    input word,
    output is_force, is_skip_low, is_skip_high, is_call, bsel, faddr, lit, mask
  );
  modport exe (
    output word,
    input is_force, is_skip_low, is_skip_high, is_call, bsel, faddr, lit, mask
  );
endinterface : btc_dec_if

// File: src/btc_decode.sv
// Combinational field decoder for the bit-force, bit-test and call words
`timescale 1ns/1ps
module btc_decode
  import btc_pkg::*;
(
  // Decoded fields
  btc_dec_if.dec d
);

  logic [BTC_OPC_W-1:0] opc;

  always_comb begin
    opc = d.word[BTC_OPC_LSB +: BTC_OPC_W];
    d.is_force = (opc == BTC_OPC_BIT_FORCE);
    d.is_skip_low = (opc == BTC_OPC_SKIP_LOW);
    d.is_skip_high = (opc == BTC_OPC_SKIP_HIGH);
    d.is_call = (opc == BTC_OPC_CALL);
    d.bsel = d.word[BTC_BSEL_LSB +: BTC_BSEL_W];
    d.faddr = d.word[BTC_FADDR_LSB +: BTC_FADDR_W];
    d.lit = d.word[BTC_LIT_LSB +: BTC_DATA_W];
    d.mask = BTC_DATA_W'(1) << d.bsel;
  end

endmodule : btc_decode

// File: test/btc_prog_mem.sv
// Program memory model feeding instruction words to the block
`timescale 1ns/1ps
module btc_prog_mem
  import btc_pkg::*;
(
  // Fetch
  input wire logic [BTC_PC_W-1:0] addr,
  output logic [BTC_WORD_W-1:0] word
);
  logic [BTC_WORD_W-1:0] mem [2**BTC_PC_W];

  // Unloaded places hold a word this block does not execute
  initial begin
    foreach (mem[i]) mem[i] = 12'hFFF;
  end

  assign word = mem[addr];
endmodule : btc_prog_mem

// File: test/tb_bit_test_and_call_decode.sv
// Self-checking bench for the bit-test-and-call block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_bit_test_and_call_decode;
  import btc_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic instr_valid = 1'b0;
  logic [7:0] status_in = 8'h00;
  logic [10:0] fetch_addr, stack_push_data;
  logic [11:0] instr_word, other_word;
  logic [7:0] file_rd_data, file_wr_data;
  logic [4:0] file_rd_addr, file_wr_addr;
  logic file_wr_en, stack_push, instr_done, nop_slot, other_valid;
  logic [7:0] regs [32];
  logic [10:0] pc = 11'h000;
  int fails = 0;
  int num_checks = 0;

  always #20 mclk = ~mclk;

  // File registers answer in the same cycle, writes land on the edge
  assign file_rd_data = regs[file_rd_addr];
  always @(posedge mclk) begin
    if (file_wr_en) regs[file_wr_addr] <= file_wr_data;
  end

  // Known contents so that a force on an untouched register writes no unknowns
  initial foreach (regs[i]) regs[i] = 8'h00;

  btc_prog_mem i_btc_prog_mem (.addr(fetch_addr), .word(instr_word));

  btc_exec i_btc_exec (
    .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
    .fetch_addr(fetch_addr), .instr_word(instr_word), .instr_valid(instr_valid),
    .status_in(status_in), .file_rd_addr(file_rd_addr), .file_rd_data(file_rd_data),
    .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data),
    .stack_push(stack_push), .stack_push_data(stack_push_data),
    .other_valid(other_valid), .other_word(other_word), .instr_done(instr_done),
    .nop_slot(nop_slot)
  );

  task end_of_test;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // Every bit position, each into its own register so no write is read back early
  task force_test;
    for (int b = 0; b < 8; b++) begin
      regs[b] = 8'h0A;
      i_btc_prog_mem.mem[pc] = {BTC_OPC_BIT_FORCE, 3'(b), 5'(b)};
      @(negedge mclk);
      `CHK("wr_en", 1'b1, file_wr_en)
      `CHK("wr_addr", 5'(b), file_wr_addr)
      `CHK("wr_data", 8'h0A | (8'h01 << b), file_wr_data)
      `CHK("done", 1'b1, instr_done)
      `CHK("pc", pc + 11'h001, fetch_addr)
      pc = pc + 11'h001;
    end
  endtask : force_test

  // Both tests on both bit values; the word after is a force that a skip must drop
  task skip_test;
    logic sk;
    for (int op = 6; op < 8; op++) begin
      for (int v = 0; v < 2; v++) begin
        sk = (op == 7) == (v == 1);
        regs[9] = (v == 1) ? 8'h10 : 8'hEF;
        i_btc_prog_mem.mem[pc] = {4'(op), 3'h4, 5'h09};
        i_btc_prog_mem.mem[pc + 11'h001] = {BTC_OPC_BIT_FORCE, 3'h0, 5'h14};
        @(negedge mclk);
        `CHK("done1", !sk, instr_done)
        `CHK("wr_en1", 1'b0, file_wr_en)
        `CHK("pc1", pc + 11'h001, fetch_addr)
        if (sk) begin
          // A stalled bus must not retire the slot before the dropped word arrives
          instr_valid = 1'b0;
          @(negedge mclk);
          `CHK("stall_nop", 1'b0, nop_slot)
          `CHK("stall_pc", pc + 11'h001, fetch_addr)
          instr_valid = 1'b1;
        end
        @(negedge mclk);
        `CHK("nop", sk, nop_slot)
        `CHK("wr_en2", !sk, file_wr_en)
        `CHK("done2", 1'b1, instr_done)
        `CHK("pc2", pc + 11'h002, fetch_addr)
        pc = pc + 11'h002;
      end
    end
  endtask : skip_test

  // Two pages, stray status bits set, and a return address crossing bit 8
  task call_test;
    logic [7:0] s [2];
    logic [7:0] k [2];
    s = '{8'hBF, 8'h40};
    k = '{8'hFF, 8'h3C};
    for (int i = 0; i < 2; i++) begin
      status_in = s[i];
      i_btc_prog_mem.mem[pc] = {BTC_OPC_CALL, k[i]};
      @(negedge mclk);
      `CHK("push", 1'b1, stack_push)
      `CHK("ret", pc + 11'h001, stack_push_data)
      `CHK("target", {s[i][6:5], 1'b0, k[i]}, fetch_addr)
      `CHK("done1", 1'b0, instr_done)
      pc = {s[i][6:5], 1'b0, k[i]};
      if (i == 0) begin
        // Frozen cycles must neither drop the push nor count as the second cycle
        clk_en = 1'b0;
        repeat (2) @(negedge mclk);
        `CHK("frozen_push", 1'b1, stack_push)
        `CHK("frozen_pc", pc, fetch_addr)
        clk_en = 1'b1;
      end
      @(negedge mclk);
      `CHK("nop", 1'b1, nop_slot)
      `CHK("done2", 1'b1, instr_done)
      `CHK("push2", 1'b0, stack_push)
      `CHK("hold", pc, fetch_addr)
    end
    // The word seen during the empty call slot is executed only now
    @(negedge mclk);
    `CHK("other", 1'b1, other_valid)
    `CHK("other_word", 12'hFFF, other_word)
    `CHK("after_call", pc + 11'h001, fetch_addr)
  endtask : call_test

  initial begin
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    instr_valid = 1'b1;
    force_test();
    skip_test();
    call_test();
    end_of_test();
  end

  // About forty-five cycles are needed; a stuck run is cut well after that
  initial begin
    #40000;
    fails++;
    end_of_test();
  end
endmodule : tb_bit_test_and_call_decode
